/* File: inc/afe_pkg.sv */
// constants and carrier types for the slot A front-end configuration bank
// assumes a 16-bit register word and an 8-bit register address from the host port
package afe_pkg;

   // register port geometry
   localparam int ADDR_W = 8;                      // register address width
   localparam int DATA_W = 16;                     // register word width

   // register offsets, printed addresses
   localparam logic [7:0] OFS_ORDER = 8'h17;       // integration_order_a
   localparam logic [7:0] OFS_WINDOW = 8'h39;      // integration_window_a
   localparam logic [7:0] OFS_SLOT_CFG = 8'h42;    // afe_slot_config_a
   localparam logic [7:0] OFS_GAIN_TABLE = 8'h55;  // channel_gain_table

   // field positions in integration_order_a
   localparam int ORDER_MSB = 3;                   // pulse_polarity_pattern top bit
   localparam int ORDER_LSB = 0;                   // pulse_polarity_pattern bottom bit

   // field positions in integration_window_a
   localparam int WIDTH_MSB = 15;                  // window_width_a
   localparam int WIDTH_LSB = 11;
   localparam int OFFSET_MSB = 10;                 // window_offset_a
   localparam int OFFSET_LSB = 0;

   // field positions in afe_slot_config_a
   localparam int MODE_MSB = 15;                   // path_mode_a
   localparam int MODE_LSB = 10;
   localparam int BUF_GAIN_BIT = 9;                // buffer_gain_sel_a
   localparam int INT_BUF_BIT = 7;                 // integrator_buffer_a
   localparam int IND_EN_BIT = 6;                  // per_channel_gain_en_a
   localparam int VREF_MSB = 5;                    // amp_reference_a
   localparam int VREF_LSB = 4;
   localparam int RSVD_MSB = 3;                    // reserved pair above the shared gain
   localparam int RSVD_LSB = 2;
   localparam int GAIN_MSB = 1;                    // gain_shared_a
   localparam int GAIN_LSB = 0;

   // field positions in channel_gain_table
   localparam int G2B_MSB = 7;                     // gain_ch2_b
   localparam int G2B_LSB = 6;
   localparam int G4_MSB = 5;                      // gain_ch4_a
   localparam int G4_LSB = 4;
   localparam int G3_MSB = 3;                      // gain_ch3_a
   localparam int G3_LSB = 2;
   localparam int G2_MSB = 1;                      // gain_ch2_a
   localparam int G2_LSB = 0;

   // field reset values
   localparam logic [3:0] RST_PATTERN = 4'h0;      // all pulses normal polarity
   localparam logic [4:0] RST_WIDTH = 5'h04;       // four microseconds
   localparam logic [10:0] RST_OFFSET = 11'h2FC;   // window offset steps
   localparam logic [5:0] RST_MODE = 6'h07;        // required path mode
   localparam logic [1:0] RST_VREF = 2'h3;         // recommended reference
   localparam logic [1:0] RST_RSVD = 2'h2;         // reserved pair default
   localparam logic [1:0] RST_GAIN = 2'h0;         // 200 kohm

   // whole-word reset values built from the fields
   localparam logic [15:0] RST_ORDER = {12'h000, RST_PATTERN};
   localparam logic [15:0] RST_WINDOW = {RST_WIDTH, RST_OFFSET};
   localparam logic [15:0] RST_SLOT_CFG = {RST_MODE, 1'h0, 1'h0, 1'h0, 1'h0, RST_VREF, RST_RSVD, RST_GAIN};
   localparam logic [15:0] RST_GAIN_TABLE = {8'h00, RST_GAIN, RST_GAIN, RST_GAIN, RST_GAIN};

   // timing
   localparam int CLK_PERIOD_NS = 40;              // clk_sys period
   localparam int WIDTH_STEP_NS = 1000;            // window width unit, 1 us
   localparam int WIDTH_STEP_CYC = WIDTH_STEP_NS / CLK_PERIOD_NS;
   localparam int OFFSET_STEP_PS = 31250;          // window offset unit, 31.25 ns

   // transimpedance per gain code, in kohm
   localparam logic [7:0] KOHM_CODE0 = 8'hC8;      // 200
   localparam logic [7:0] KOHM_CODE1 = 8'h64;      // 100
   localparam logic [7:0] KOHM_CODE2 = 8'h32;      // 50
   localparam logic [7:0] KOHM_CODE3 = 8'h19;      // 25

   // amplifier reference per code, in mV
   localparam logic [10:0] VREF_MV_CODE0 = 11'h474; // 1.14 V
   localparam logic [10:0] VREF_MV_CODE1 = 11'h3F2; // 1.01 V
   localparam logic [10:0] VREF_MV_CODE2 = 11'h384; // 0.90 V
   localparam logic [10:0] VREF_MV_CODE3 = 11'h4F6; // 1.27 V

   // decoded configuration handed to the analog path
   typedef struct packed {
      logic pulse_reverse;                         // polarity of the latest pulse
      logic [4:0] window_width;                    // width in 1 us steps
      logic [9:0] window_width_cyc;                // width in clk_sys cycles
      logic [10:0] window_offset;                  // offset in 31.25 ns steps
      logic [5:0] path_mode;                       // path mode field
      logic buffer_gain_sel;                       // 0 unity, 1 gain 0.7
      logic integrator_buffer;                     // integrator as buffer
      logic [1:0] amp_reference;                   // reference code
      logic [10:0] amp_reference_mv;               // reference in mV
      logic [3:0][1:0] gain_code;                  // effective codes, index 0 is channel 1
      logic [3:0][7:0] gain_kohm;                  // effective transimpedance
      logic [1:0] gain_ch2_b;                      // slot B channel 2 effective code
      logic [7:0] gain_ch2_b_kohm;                 // slot B channel 2 transimpedance
   } afe_cfg_type;

   // whole state of the bank except the address hit flag
   typedef struct packed {
      logic [15:0] order_reg;                      // integration_order_a
      logic [15:0] window_reg;                     // integration_window_a
      logic [15:0] slot_cfg_reg;                   // afe_slot_config_a
      logic [15:0] gain_table_reg;                 // channel_gain_table
      logic [1:0] pulse_idx;                       // position in the four-pulse group
      logic [15:0] rd_data;                        // read answer
      logic rd_valid;                              // read answer strobe
      afe_cfg_type cfg;                            // decoded outputs
   } afe_state_type;

endpackage

/* File: design/afe_gain_sel.sv */
// one channel's gain selector: shared code or its own code, plus transimpedance
// assumes the caller registers the outputs
`timescale 1ns/100ps
module afe_gain_sel (
   input wire logic ind_en,          // per-channel gains enabled
   input wire logic [1:0] own_code,  // channel's own gain field
   input wire logic [1:0] shared_code, // fallback shared gain field
   output logic [1:0] code,          // effective gain code
   output logic [7:0] kohm           // effective transimpedance in kohm
);

   // own field only counts when individual gains are on
   always_comb begin
      code = ind_en ? own_code : shared_code;
      unique case (code)
         2'h0: kohm = afe_pkg::KOHM_CODE0;
         2'h1: kohm = afe_pkg::KOHM_CODE1;
         2'h2: kohm = afe_pkg::KOHM_CODE2;
         2'h3: kohm = afe_pkg::KOHM_CODE3;
      endcase
   end

endmodule

/* File: design/afe_slot_a_regs.sv */
// slot A front-end configuration bank with decoded outputs for the analog path
// assumes a host-side serial front end (I2C or SPI) that turns transfers into
// single-cycle word strobes on the register port below
`timescale 1ns/100ps
module afe_slot_a_regs (
   input wire logic clk_sys,                     // system clock, 25 MHz
   input wire logic rst_n,                       // asynchronous reset, active low
   input wire logic reg_wr_en,                   // write strobe, one cycle
   input wire logic reg_rd_en,                   // read strobe, one cycle
   input wire logic [7:0] reg_addr,              // register address
   input wire logic [15:0] reg_wr_data,          // write word
   output logic [15:0] reg_rd_data,              // read word, held until next read
   output logic reg_rd_valid,                    // read answer strobe
   output logic reg_hit,                         // last access hit a mapped register
   input wire logic slot_start,                  // start of a slot A frame
   input wire logic pulse_strobe,                // one LED pulse of slot A
   input wire logic slot_b_ind_en,               // slot B individual gain enable
   input wire logic [1:0] gain_shared_b,         // slot B shared gain code
   output afe_pkg::afe_cfg_type cfg              // decoded configuration
);

   // state and its next value
   afe_pkg::afe_state_type s;                    // registered state
   afe_pkg::afe_state_type next_s;               // next state
   logic hit;                                    // registered address hit flag
   logic next_hit;                               // next address hit flag

   // gain selector wiring, channels 1..4 of slot A and channel 2 of slot B
   logic [2:0][1:0] own_code;                    // per-channel fields of slot A
   logic [2:0][1:0] sel_code;                    // selected codes of slot A
   logic [2:0][7:0] sel_kohm;                    // selected transimpedance of slot A
   logic [1:0] b2_code;                          // slot B channel 2 selected code
   logic [7:0] b2_kohm;                          // slot B channel 2 transimpedance
   logic [1:0] ch1_code;                         // slot A channel 1 code
   logic [7:0] ch1_kohm;                         // slot A channel 1 transimpedance
   logic ind_en;                                 // per_channel_gain_en_a, post-write
   logic [1:0] shared_code;                      // gain_shared_a, post-write

   // the selectors look at the post-write words so outputs track a write at once
   always_comb begin
      ind_en = next_s.slot_cfg_reg[afe_pkg::IND_EN_BIT];
      shared_code = next_s.slot_cfg_reg[afe_pkg::GAIN_MSB:afe_pkg::GAIN_LSB];
      own_code[0] = next_s.gain_table_reg[afe_pkg::G2_MSB:afe_pkg::G2_LSB];
      own_code[1] = next_s.gain_table_reg[afe_pkg::G3_MSB:afe_pkg::G3_LSB];
      own_code[2] = next_s.gain_table_reg[afe_pkg::G4_MSB:afe_pkg::G4_LSB];
   end

   // channels 2..4 of slot A: own field if enabled, else the shared field
   for (genvar ch = 0; ch < 3; ch++) begin : g_ch
      afe_gain_sel u_sel (
         .ind_en(ind_en),
         .own_code(own_code[ch]),
         .shared_code(shared_code),
         .code(sel_code[ch]),
         .kohm(sel_kohm[ch])
      );
   end

   // channel 1 always takes the shared field, both with and without individual gains
   afe_gain_sel u_ch1 (
      .ind_en(1'b0),
      .own_code(2'h0),
      .shared_code(shared_code),
      .code(ch1_code),
      .kohm(ch1_kohm)
   );

   // slot B channel 2 only honours its field when slot B enables individual gains
   afe_gain_sel u_b2 (
      .ind_en(slot_b_ind_en),
      .own_code(next_s.gain_table_reg[afe_pkg::G2B_MSB:afe_pkg::G2B_LSB]),
      .shared_code(gain_shared_b),
      .code(b2_code),
      .kohm(b2_kohm)
   );

   // next-state logic: register writes, reads, pulse walk and output decode
   always_comb begin
      next_s = s;
      next_hit = hit;
      next_s.rd_valid = 1'b0;

      // writes store the whole word; reserved bits keep what the host wrote
      if (reg_wr_en) begin
         case (reg_addr)
            afe_pkg::OFS_ORDER: begin
               next_s.order_reg = reg_wr_data;
            end
            afe_pkg::OFS_WINDOW: begin
               next_s.window_reg = reg_wr_data;
            end
            afe_pkg::OFS_SLOT_CFG: begin
               next_s.slot_cfg_reg = reg_wr_data;
            end
            afe_pkg::OFS_GAIN_TABLE: begin
               next_s.gain_table_reg = reg_wr_data;
            end
            default: begin
               // unmapped write is dropped
            end
         endcase
      end

      // reads return the pre-write word; unmapped addresses read zero
      if (reg_rd_en) begin
         next_s.rd_valid = 1'b1;
         case (reg_addr)
            afe_pkg::OFS_ORDER: begin
               next_s.rd_data = s.order_reg;
            end
            afe_pkg::OFS_WINDOW: begin
               next_s.rd_data = s.window_reg;
            end
            afe_pkg::OFS_SLOT_CFG: begin
               next_s.rd_data = s.slot_cfg_reg;
            end
            afe_pkg::OFS_GAIN_TABLE: begin
               next_s.rd_data = s.gain_table_reg;
            end
            default: begin
               next_s.rd_data = 16'h0000;
            end
         endcase
      end

      // hit flag reflects the most recent access of either kind
      if (reg_wr_en || reg_rd_en) begin
         next_hit = (reg_addr == afe_pkg::OFS_ORDER) || (reg_addr == afe_pkg::OFS_WINDOW) ||
                    (reg_addr == afe_pkg::OFS_SLOT_CFG) || (reg_addr == afe_pkg::OFS_GAIN_TABLE);
      end

      // a new frame restarts the group at pulse 1
      if (slot_start) begin
         next_s.pulse_idx = 2'h0;
      end

      // each pulse takes its polarity from its bit, then the index wraps after four
      if (pulse_strobe) begin
         next_s.cfg.pulse_reverse = s.order_reg[afe_pkg::ORDER_LSB + int'(next_s.pulse_idx)];
         next_s.pulse_idx = next_s.pulse_idx + 2'h1;
      end

      // window fields; width is also given in clock cycles for the sequencer
      next_s.cfg.window_width = next_s.window_reg[afe_pkg::WIDTH_MSB:afe_pkg::WIDTH_LSB];
      next_s.cfg.window_width_cyc = 10'(next_s.cfg.window_width) * 10'(afe_pkg::WIDTH_STEP_CYC);
      next_s.cfg.window_offset = next_s.window_reg[afe_pkg::OFFSET_MSB:afe_pkg::OFFSET_LSB];

      // mode and integrator options are passed through as written
      next_s.cfg.path_mode = next_s.slot_cfg_reg[afe_pkg::MODE_MSB:afe_pkg::MODE_LSB];
      next_s.cfg.buffer_gain_sel = next_s.slot_cfg_reg[afe_pkg::BUF_GAIN_BIT];
      // the bank does not police the path mode; a wrong combination is the host's to avoid
      next_s.cfg.integrator_buffer = next_s.slot_cfg_reg[afe_pkg::INT_BUF_BIT];

      // amplifier reference code and its voltage
      next_s.cfg.amp_reference = next_s.slot_cfg_reg[afe_pkg::VREF_MSB:afe_pkg::VREF_LSB];
      unique case (next_s.cfg.amp_reference)
         2'h0: next_s.cfg.amp_reference_mv = afe_pkg::VREF_MV_CODE0;
         2'h1: next_s.cfg.amp_reference_mv = afe_pkg::VREF_MV_CODE1;
         2'h2: next_s.cfg.amp_reference_mv = afe_pkg::VREF_MV_CODE2;
         2'h3: next_s.cfg.amp_reference_mv = afe_pkg::VREF_MV_CODE3;
      endcase

      // effective gains; with individual gains off all four follow the shared field
      next_s.cfg.gain_code[0] = ch1_code;
      next_s.cfg.gain_kohm[0] = ch1_kohm;
      for (int ch = 0; ch < 3; ch++) begin
         next_s.cfg.gain_code[ch + 1] = sel_code[ch];
         next_s.cfg.gain_kohm[ch + 1] = sel_kohm[ch];
      end
      next_s.cfg.gain_ch2_b = b2_code;
      next_s.cfg.gain_ch2_b_kohm = b2_kohm;
   end

   // state register; reset loads the documented defaults and matching outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s.order_reg <= afe_pkg::RST_ORDER;
         s.window_reg <= afe_pkg::RST_WINDOW;
         s.slot_cfg_reg <= afe_pkg::RST_SLOT_CFG;
         s.gain_table_reg <= afe_pkg::RST_GAIN_TABLE;
         s.pulse_idx <= 2'h0;
         s.rd_data <= 16'h0000;
         s.rd_valid <= 1'b0;
         s.cfg.pulse_reverse <= 1'b0;
         s.cfg.window_width <= afe_pkg::RST_WIDTH;
         s.cfg.window_width_cyc <= 10'(afe_pkg::RST_WIDTH) * 10'(afe_pkg::WIDTH_STEP_CYC);
         s.cfg.window_offset <= afe_pkg::RST_OFFSET;
         s.cfg.path_mode <= afe_pkg::RST_MODE;
         s.cfg.buffer_gain_sel <= 1'b0;
         s.cfg.integrator_buffer <= 1'b0;
         s.cfg.amp_reference <= afe_pkg::RST_VREF;
         s.cfg.amp_reference_mv <= afe_pkg::VREF_MV_CODE3;
         s.cfg.gain_code <= {4{afe_pkg::RST_GAIN}};
         s.cfg.gain_kohm <= {4{afe_pkg::KOHM_CODE0}};
         s.cfg.gain_ch2_b <= 2'h0;
         s.cfg.gain_ch2_b_kohm <= afe_pkg::KOHM_CODE0;
         hit <= 1'b0;
      end else begin
         s <= next_s;
         hit <= next_hit;
      end
   end

   // outputs come straight from the state flops
   assign reg_rd_data = s.rd_data;
   assign reg_rd_valid = s.rd_valid;
   assign reg_hit = hit;
   assign cfg = s.cfg;

endmodule

/* File: bench/afe_slot_a_regs_sva.sv */
// port checker for the slot A front-end bank
// assumes one clk_sys domain; shadow words are rebuilt here from the host writes
`timescale 1ns/100ps
module afe_slot_a_regs_sva (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic reg_wr_en, // write strobe
   input wire logic reg_rd_en, // read strobe
   input wire logic [7:0] reg_addr, // register address
   input wire logic [15:0] reg_wr_data, // write word
   input wire logic [15:0] reg_rd_data, // read word
   input wire logic reg_rd_valid, // read answer strobe
   input wire logic reg_hit, // mapped access flag
   input wire logic slot_start, // group restart
   input wire logic pulse_strobe, // one pulse
   input wire logic slot_b_ind_en, // slot B individual enable
   input wire logic [1:0] gain_shared_b, // slot B shared code
   input wire afe_pkg::afe_cfg_type cfg // decoded configuration
);
   logic [15:0] sh_ord, sh_win, sh_cfg, sh_gt; // shadow words
   logic [15:0] rd_word; // word a read at this edge should return
   logic [1:0] idx; // position in the four-pulse group
   logic [1:0] use_idx; // position a pulse in this cycle uses
   logic mapped; // address hits the bank
   assign use_idx = slot_start ? 2'h0 : idx;
   assign mapped = reg_addr inside {8'h17, 8'h39, 8'h42, 8'h55};
   // read mux over shadows; unmapped reads answer zero
   always_comb begin
      case (reg_addr)
         8'h17: rd_word = sh_ord;
         8'h39: rd_word = sh_win;
         8'h42: rd_word = sh_cfg;
         8'h55: rd_word = sh_gt;
         default: rd_word = 16'h0000;
      endcase
   end
   // shadows follow writes on the same edge the bank takes them
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sh_ord <= 16'h0000;
         sh_win <= 16'h22FC;
         sh_cfg <= 16'h1C38;
         sh_gt <= 16'h0000;
         idx <= 2'h0;
      end else begin
         if (reg_wr_en && reg_addr == 8'h17) sh_ord <= reg_wr_data;
         if (reg_wr_en && reg_addr == 8'h39) sh_win <= reg_wr_data;
         if (reg_wr_en && reg_addr == 8'h42) sh_cfg <= reg_wr_data;
         if (reg_wr_en && reg_addr == 8'h55) sh_gt <= reg_wr_data;
         if (pulse_strobe) idx <= use_idx + 2'h1;
         else if (slot_start) idx <= 2'h0;
      end
   end
   // own lookup tables, kept apart from the design's decode on purpose
   function automatic logic [7:0] kohm(input logic [1:0] c);
      return (c == 2'h0) ? 8'hC8 : (c == 2'h1) ? 8'h64 : (c == 2'h2) ? 8'h32 : 8'h19;
   endfunction
   function automatic logic [10:0] mv(input logic [1:0] c);
      return (c == 2'h0) ? 11'h474 : (c == 2'h1) ? 11'h3F2 : (c == 2'h2) ? 11'h384 : 11'h4F6;
   endfunction
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_pulse_order: assert property (pulse_strobe |=> cfg.pulse_reverse == $past(sh_ord[use_idx]))
      else $error("pulse polarity differs from its order bit");
   chk_width_field: assert property (cfg.window_width == sh_win[15:11] && cfg.window_width_cyc == 10'(sh_win[15:11] * 25))
      else $error("window width differs from stored field");
   chk_offset_field: assert property (cfg.window_offset == sh_win[10:0])
      else $error("window offset differs from stored field");
   chk_buffer_gain: assert property (cfg.buffer_gain_sel == sh_cfg[9] &&
      cfg.integrator_buffer == sh_cfg[7] && cfg.path_mode == sh_cfg[15:10])
      else $error("buffer gain, mode or integrator bits differ");
   chk_own_gains: assert property (sh_cfg[6] |-> cfg.gain_code == {sh_gt[5:4], sh_gt[3:2], sh_gt[1:0], sh_cfg[1:0]})
      else $error("individual gains not taken from own fields");
   chk_shared_gains: assert property (!sh_cfg[6] |-> cfg.gain_code == {4{sh_cfg[1:0]}})
      else $error("shared gain not applied to all channels");
   chk_kohm_map: assert property (cfg.gain_kohm[0] == kohm(cfg.gain_code[0]) && cfg.gain_kohm[3] == kohm(cfg.gain_code[3]))
      else $error("transimpedance does not match gain code");
   chk_slot_b_gain: assert property ($stable(slot_b_ind_en) && $stable(gain_shared_b) |-> cfg.gain_ch2_b == (slot_b_ind_en ? sh_gt[7:6] : gain_shared_b))
      else $error("slot B channel 2 gain wrong");
   chk_vref_code: assert property (cfg.amp_reference == sh_cfg[5:4] && cfg.amp_reference_mv == mv(sh_cfg[5:4]))
      else $error("amplifier reference wrong");
   chk_read_answer: assert property (reg_rd_en |=> reg_rd_valid && reg_rd_data == $past(rd_word))
      else $error("read answer missing or wrong");
   chk_valid_pulse: assert property (!reg_rd_en |=> !reg_rd_valid)
      else $error("read valid without a read");
   chk_hit_flag: assert property ((reg_rd_en || reg_wr_en) |=> reg_hit == $past(mapped))
      else $error("hit flag wrong after access");
   cover property (pulse_strobe && slot_start);
   cover property (reg_rd_en && !mapped);
   cover property (sh_cfg[6] && sh_gt[5:0] != 6'h00);
endmodule

/* File: bench/afe_host_model.sv */
// host model: plays the serial front end that turns transfers into word strobes
// assumes the bank samples on rising clk_sys; this side drives at the falling edge
`timescale 1ns/100ps
module afe_host_model (
   input wire logic clk_sys, // system clock
   output logic reg_wr_en, // write strobe
   output logic reg_rd_en, // read strobe
   output logic [7:0] reg_addr, // register address
   output logic [15:0] reg_wr_data, // write word
   input wire logic [15:0] reg_rd_data, // read word
   input wire logic reg_rd_valid // read answer strobe
);
   // idle port at time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wr_data = 16'h0000;
   end
   // one-cycle write; released lines show the inverse so stale data is never trusted
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      if (a == 8'h17) d[15:4] = 12'h000;
      if (a == 8'h42) d[15:7] = {6'h07, d[9], 2'h0};
      @(negedge clk_sys);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      @(negedge clk_sys);
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~d;
   endtask
   // one-cycle read; the answer stands one cycle and is taken in that cycle
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge clk_sys);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      d = reg_rd_data;
      v = reg_rd_valid;
   endtask
endmodule

/* File: bench/afe_slot_a_regs_tb.sv */
// self-checking bench for the slot A front-end bank
// assumes the host model owns the register port; pulses and slot B inputs come from here
`timescale 1ns/100ps
module afe_slot_a_regs_tb;
   logic clk_sys, rst_n; // clock and async reset
   logic reg_wr_en, reg_rd_en, reg_rd_valid, reg_hit, vld; // port strobes, flags, last valid
   logic [7:0] reg_addr; // register address
   logic [15:0] reg_wr_data, reg_rd_data, rdv; // write word, read word, last read taken
   logic slot_start, pulse_strobe, slot_b_ind_en; // pulse and slot B controls
   logic [1:0] gain_shared_b, k; // slot B shared code, loop code
   afe_pkg::afe_cfg_type cfg; // decoded configuration
   int error_cnt, n_compared; // mismatch and comparison counts
   logic [7:0] kohm_tab [4] = '{8'hC8, 8'h64, 8'h32, 8'h19}; // transimpedance per code
   logic [10:0] mv_tab [4] = '{11'h474, 11'h3F2, 11'h384, 11'h4F6}; // reference per code
   logic [7:0] ofs_tab [4] = '{8'h17, 8'h39, 8'h42, 8'h55}; // mapped offsets
   logic [15:0] rst_tab [4] = '{16'h0000, 16'h22FC, 16'h1C38, 16'h0000}; // reset words
   // 25 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   afe_slot_a_regs afe_slot_a_regs_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit), .slot_start(slot_start), .pulse_strobe(pulse_strobe),
      .slot_b_ind_en(slot_b_ind_en), .gain_shared_b(gain_shared_b), .cfg(cfg));
   afe_host_model afe_host_model_i (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));
   // compare and count; an unknown bit matches only an unknown expected bit
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
      end
   endtask
   // legal slot config word: mode 0x07, reserved pair as at reset, integrator normal
   function automatic logic [15:0] cw(input logic bg, input logic ind, input logic [1:0] vr, input logic [1:0] g);
      return {6'h07, bg, 1'b0, 1'b0, ind, vr, 2'h2, g};
   endfunction
   // one pulse, optionally together with a group restart
   task automatic pulse(input logic st);
      @(negedge clk_sys);
      slot_start = st;
      pulse_strobe = 1'b1;
      @(negedge clk_sys);
      slot_start = 1'b0;
      pulse_strobe = 1'b0;
   endtask
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst_n = 1'b0;
      slot_start = 1'b0;
      pulse_strobe = 1'b0;
      slot_b_ind_en = 1'b0;
      gain_shared_b = 2'h0;
      error_cnt = 0;
      n_compared = 0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         afe_host_model_i.rd(ofs_tab[i], rdv, vld);
         check(rdv, rst_tab[i], "reset word");
         check(16'(vld), 16'h0001, "read valid");
      end
      check(16'(cfg.window_width_cyc), 16'h0064, "width cycles");
      check(16'(cfg.window_offset), 16'h02FC, "offset");
      check(16'(cfg.amp_reference_mv), 16'h04F6, "reference");
      $display("test reset values done");
      afe_host_model_i.wr(8'h39, 16'hFFFF);
      afe_host_model_i.wr(8'h20, 16'h1234);
      check(16'(reg_hit), 16'h0000, "unmapped write hit");
      afe_host_model_i.rd(8'h39, rdv, vld);
      check(rdv, 16'hFFFF, "window readback");
      check(16'(cfg.window_width), 16'h001F, "width max");
      check(16'(cfg.window_offset), 16'h07FF, "offset max");
      afe_host_model_i.rd(8'h20, rdv, vld);
      check(rdv, 16'h0000, "unmapped read");
      check(16'(reg_hit), 16'h0000, "unmapped read hit");
      $display("test readback done");
      afe_host_model_i.wr(8'h17, 16'h000A);
      // expected polarity per pulse, restart at pulses 0 and 6: 0101010 from the first
      for (int i = 0; i < 7; i++) begin
         pulse(i == 0 || i == 6);
         check(16'(cfg.pulse_reverse), 16'(7'h2A >> i) & 16'h0001, "pulse polarity");
      end
      $display("test pulse order done");
      afe_host_model_i.wr(8'h55, 16'h00E4);
      for (int c = 0; c < 4; c++) begin
         k = 2'(c);
         afe_host_model_i.wr(8'h42, cw(k[0], 1'b0, k, k));
         for (int ch = 0; ch < 4; ch++) begin
            check(16'(cfg.gain_kohm[ch]), 16'(kohm_tab[c]), "shared gain");
         end
         check(16'(cfg.amp_reference_mv), 16'(mv_tab[c]), "reference code");
         check(16'(cfg.buffer_gain_sel), 16'(k[0]), "buffer gain");
      end
      $display("test shared gains done");
      afe_host_model_i.wr(8'h42, cw(1'b0, 1'b1, 2'h3, 2'h1));
      check(16'(cfg.gain_code), 16'h0091, "individual codes");
      check(16'(cfg.gain_kohm[3]), 16'h0032, "channel 4 kohm");
      slot_b_ind_en = 1'b1;
      repeat (2) @(negedge clk_sys);
      check(16'(cfg.gain_ch2_b), 16'h0003, "slot B own gain");
      check(16'(cfg.gain_ch2_b_kohm), 16'h0019, "slot B kohm");
      slot_b_ind_en = 1'b0;
      gain_shared_b = 2'h1;
      repeat (2) @(negedge clk_sys);
      check(16'(cfg.gain_ch2_b), 16'h0001, "slot B shared gain");
      $display("test individual gains done");
      end_of_test();
   end
   // watchdog well beyond the roughly 50 cycles the tests need
   initial begin
      #100000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end
endmodule
bind afe_slot_a_regs afe_slot_a_regs_sva afe_slot_a_regs_sva_i (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
   .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit), .slot_start(slot_start),
   .pulse_strobe(pulse_strobe), .slot_b_ind_en(slot_b_ind_en), .gain_shared_b(gain_shared_b), .cfg(cfg));
